//--- src/trng_top.sv
// Random byte generator: task control, noise sampling, debias, byte assembly and registers
module trng_top
    import trng_pkg::*;
#(
    parameter int START_DELAY_CYCLES = START_DELAY_CYC,
    parameter int BIT_CYCLES = BIT_CYC,
    parameter int BUFFER_DEPTH = BUF_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Noise source
    input wire logic noise_bit_i,
    // Register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // Event interconnect
    input wire logic [NUM_CHANNELS-1:0] ev_chan_i,
    output logic [NUM_CHANNELS-1:0] pub_chan_o,
    // Interrupt
    output logic irq_o
);
    trng_state_t state_reg;
    logic noise_meta_reg;
    logic noise_sync_reg;
    logic [31:0] warm_cnt_reg;
    logic [31:0] div_cnt_reg;
    logic sample_en_reg;
    logic pair_have_reg;
    logic pair_first_reg;
    logic [BYTE_W-1:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic byte_full_reg;
    logic [BYTE_W-1:0] value_reg;
    logic evt_reg;
    logic inten_reg;
    logic [31:0] start_sub_reg;
    logic [31:0] stop_sub_reg;
    logic [31:0] pub_cfg_reg;
    logic [31:0] event_task_shortcuts_reg;
    logic [31:0] cfg_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic irq_reg;
    logic [NUM_CHANNELS-1:0] pub_reg;

    logic wr_start;
    logic wr_stop;
    logic sub_start_hit;
    logic sub_stop_hit;
    logic short_stop;
    logic start_trig;
    logic stop_trig;
    logic warm_done;
    logic corr_on;
    logic take_raw;
    logic bit_valid;
    logic bit_val;
    logic push_ready;
    logic push_accept;
    logic buf_out_valid;
    logic [BYTE_W-1:0] buf_out_data;
    logic drain_ready;
    logic value_load;
    logic buf_flush;
    logic evt_clear;
    logic [DATA_W-1:0] rd_mux;

    // Noise pin synchroniser; nothing else ever feeds the generator
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            noise_meta_reg <= 1'b0;
            noise_sync_reg <= 1'b0;
        end else begin
            noise_meta_reg <= noise_bit_i; // [RULE10]
            noise_sync_reg <= noise_meta_reg;
        end
    end

    // Task triggers
    assign wr_start = wr_i && (addr_i == OFS_START_TASK) && wdata_i[TASK_TRIG_BIT]; // [RULE11]
    assign wr_stop = wr_i && (addr_i == OFS_STOP_TASK) && wdata_i[TASK_TRIG_BIT]; // [RULE11]
    assign sub_start_hit = start_sub_reg[CHAN_EN_BIT] && ev_chan_i[start_sub_reg[CHAN_IDX_W-1:0]]; // [RULE12]
    assign sub_stop_hit = stop_sub_reg[CHAN_EN_BIT] && ev_chan_i[stop_sub_reg[CHAN_IDX_W-1:0]]; // [RULE12]
    assign short_stop = value_load && event_task_shortcuts_reg[SHORT_STOP_BIT]; // [RULE14]
    assign start_trig = wr_start || sub_start_hit; // [RULE1]
    assign stop_trig = wr_stop || sub_stop_hit || short_stop; // [RULE2]
    assign warm_done = (warm_cnt_reg == 32'(START_DELAY_CYCLES - 1));

    // Run control; stop wins over a simultaneous start, start while busy is ignored
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
        end else if (stop_trig) begin
            state_reg <= ST_IDLE; // [RULE2]
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_trig) begin
                        state_reg <= ST_WARMUP; // [RULE1]
                    end
                end
                ST_WARMUP: begin
                    if (warm_done) begin
                        state_reg <= ST_RUN; // [RULE15]
                    end
                end
                ST_RUN: begin
                    state_reg <= ST_RUN; // [RULE3]
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // One-time start delay, counted only in warm-up
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            warm_cnt_reg <= '0;
        end else if (state_reg != ST_WARMUP) begin
            warm_cnt_reg <= '0;
        end else begin
            warm_cnt_reg <= warm_cnt_reg + 32'(1); // [RULE15]
        end
    end

    // Bit-rate divider: one sample enable per bit period while running
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt_reg <= '0;
            sample_en_reg <= 1'b0;
        end else if (state_reg != ST_RUN || stop_trig) begin
            div_cnt_reg <= '0;
            sample_en_reg <= 1'b0;
        end else if (div_cnt_reg == 32'(BIT_CYCLES - 1)) begin
            div_cnt_reg <= '0;
            sample_en_reg <= 1'b1; // [RULE16]
        end else begin
            div_cnt_reg <= div_cnt_reg + 32'(1);
            sample_en_reg <= 1'b0;
        end
    end

    // Debias: pairs of raw bits, unequal pair gives its first bit, equal pair is dropped
    assign corr_on = cfg_reg[CFG_CORR_BIT]; // [RULE8]
    assign take_raw = sample_en_reg && !byte_full_reg && (state_reg == ST_RUN);
    assign bit_valid = take_raw && (!corr_on || (pair_have_reg && (pair_first_reg != noise_sync_reg))); // [RULE6]
    assign bit_val = corr_on ? pair_first_reg : noise_sync_reg;

    // Dropped pairs make corrected byte time open-ended
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pair_have_reg <= 1'b0;
            pair_first_reg <= 1'b0;
        end else if (state_reg != ST_RUN || !corr_on) begin
            pair_have_reg <= 1'b0;
            pair_first_reg <= 1'b0;
        end else if (take_raw) begin
            pair_have_reg <= !pair_have_reg; // [RULE17]
            if (!pair_have_reg) begin
                pair_first_reg <= noise_sync_reg; // [RULE6]
            end
        end
    end

    // Serial-in byte assembly, held until the buffer takes it
    assign push_accept = byte_full_reg && push_ready;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_reg <= '0;
            bit_cnt_reg <= '0;
            byte_full_reg <= 1'b0;
        end else if (state_reg != ST_RUN) begin
            bit_cnt_reg <= '0;
            byte_full_reg <= 1'b0;
        end else if (push_accept) begin
            bit_cnt_reg <= '0;
            byte_full_reg <= 1'b0;
        end else if (bit_valid) begin
            shift_reg <= {shift_reg[BYTE_W-2:0], bit_val}; // [RULE7]
            bit_cnt_reg <= bit_cnt_reg + 3'(1);
            if (bit_cnt_reg == 3'(BYTE_W - 1)) begin
                byte_full_reg <= 1'b1;
            end
        end
    end

    // Value is held steady during a read of it
    assign buf_flush = (state_reg != ST_RUN);
    assign drain_ready = (state_reg == ST_RUN) && !(rd_i && (addr_i == OFS_VALUE));
    assign value_load = buf_out_valid && drain_ready; // [RULE9]

    trng_byte_buf #(
        .WIDTH(BYTE_W),
        .DEPTH(BUFFER_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .flush_i(buf_flush),
        .in_valid_i(byte_full_reg),
        .in_ready_o(push_ready),
        .in_data_i(shift_reg),
        .out_valid_o(buf_out_valid),
        .out_ready_i(drain_ready),
        .out_data_o(buf_out_data)
    );

    // Value register, overwritten by each new byte
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            value_reg <= '0;
        end else if (value_load) begin
            value_reg <= buf_out_data; // [RULE3] [RULE5] [RULE7]
        end
    end

    // Event flag: set wins over a clear in the same cycle
    assign evt_clear = wr_i && (addr_i == OFS_EVENT) && !wdata_i[EVT_BIT];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            evt_reg <= 1'b0;
        end else if (value_load) begin
            evt_reg <= 1'b1; // [RULE4]
        end else if (evt_clear) begin
            evt_reg <= 1'b0; // [RULE19]
        end
    end

    // Interrupt enable, set and clear by writing ones
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            inten_reg <= 1'b0;
        end else if (wr_i && (addr_i == OFS_INTEN_SET) && wdata_i[INT_READY_BIT]) begin
            inten_reg <= 1'b1; // [RULE18]
        end else if (wr_i && (addr_i == OFS_INTEN_CLR) && wdata_i[INT_READY_BIT]) begin
            inten_reg <= 1'b0; // [RULE18]
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_sub_reg <= RESET_WORD;
            stop_sub_reg <= RESET_WORD;
            pub_cfg_reg <= RESET_WORD;
            event_task_shortcuts_reg <= RESET_WORD;
            cfg_reg <= RESET_WORD;
        end else if (wr_i) begin
            if (addr_i == OFS_START_SUB) begin
                start_sub_reg <= wdata_i & CHAN_MASK; // [RULE12]
            end else if (addr_i == OFS_STOP_SUB) begin
                stop_sub_reg <= wdata_i & CHAN_MASK; // [RULE12]
            end else if (addr_i == OFS_PUBLISH) begin
                pub_cfg_reg <= wdata_i & CHAN_MASK; // [RULE13]
            end else if (addr_i == OFS_EVENT_TASK_SHORTCUTS) begin
                event_task_shortcuts_reg <= wdata_i & EVENT_TASK_SHORTCUTS_MASK; // [RULE14]
            end else if (addr_i == OFS_CONFIG) begin
                cfg_reg <= wdata_i & CFG_MASK; // [RULE8]
            end
        end
    end

    // Interrupt and publish outputs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= evt_reg && inten_reg; // [RULE18]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pub_reg <= '0;
        end else begin
            pub_reg <= '0;
            if (value_load && pub_cfg_reg[CHAN_EN_BIT]) begin
                pub_reg[pub_cfg_reg[CHAN_IDX_W-1:0]] <= 1'b1; // [RULE13]
            end
        end
    end

    // Read mux; task registers and unmapped addresses read zero
    always_comb begin
        rd_mux = RESET_WORD;
        if (addr_i == OFS_START_SUB) begin
            rd_mux = start_sub_reg;
        end else if (addr_i == OFS_STOP_SUB) begin
            rd_mux = stop_sub_reg;
        end else if (addr_i == OFS_EVENT) begin
            rd_mux[EVT_BIT] = evt_reg;
        end else if (addr_i == OFS_PUBLISH) begin
            rd_mux = pub_cfg_reg;
        end else if (addr_i == OFS_EVENT_TASK_SHORTCUTS) begin
            rd_mux = event_task_shortcuts_reg;
        end else if (addr_i == OFS_INTEN_SET || addr_i == OFS_INTEN_CLR) begin
            rd_mux[INT_READY_BIT] = inten_reg;
        end else if (addr_i == OFS_CONFIG) begin
            rd_mux = cfg_reg;
        end else if (addr_i == OFS_VALUE) begin
            rd_mux[BYTE_W-1:0] = value_reg;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= '0;
        end else if (rd_i) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign pub_chan_o = pub_reg;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_START_WARMUP: assert property ( // [RULE1]
        (state_reg == ST_IDLE) && start_trig && !stop_trig |=> state_reg == ST_WARMUP)
        else $error("start task did not enter warm-up");

    AST_STOP_IDLE: assert property ( // [RULE2]
        stop_trig |=> (state_reg == ST_IDLE) && !sample_en_reg)
        else $error("stop task did not halt generation");

    AST_WARMUP_DONE: assert property ( // [RULE15]
        (state_reg == ST_WARMUP) && warm_done && !stop_trig |=> state_reg == ST_RUN)
        else $error("warm-up did not end at its count");

    AST_RUN_FROM_WARMUP: assert property ( // [RULE15]
        (state_reg == ST_RUN) && ($past(state_reg) != ST_RUN) |-> $past(warm_done))
        else $error("run entered before the start delay");

    AST_EVENT_ON_LOAD: assert property ( // [RULE4]
        value_load |=> evt_reg && (value_reg == $past(buf_out_data)))
        else $error("value load without event flag");

    AST_VALUE_ONLY_ON_LOAD: assert property ( // [RULE5]
        (value_reg != $past(value_reg)) |-> $past(value_load))
        else $error("value changed without a load");

    AST_EVENT_STICKY: assert property ( // [RULE19]
        evt_reg && !evt_clear |=> evt_reg)
        else $error("event flag dropped without a zero write");

    AST_IRQ_TRACK: assert property ( // [RULE18]
        ##1 (irq_o == ($past(evt_reg) && $past(inten_reg))))
        else $error("interrupt does not follow flag and enable");

    AST_SHORT_STOP: assert property ( // [RULE14]
        value_load && event_task_shortcuts_reg[SHORT_STOP_BIT] |=> state_reg == ST_IDLE)
        else $error("shortcut did not stop the generator");

    AST_PUBLISH: assert property ( // [RULE13]
        value_load && pub_cfg_reg[CHAN_EN_BIT] |=> pub_chan_o[$past(pub_cfg_reg[CHAN_IDX_W-1:0])] ##1 !(|pub_chan_o))
        else $error("publish pulse missing or too long");

    AST_SAMPLE_SPACING: assert property ( // [RULE16]
        sample_en_reg |=> !sample_en_reg)
        else $error("sample enables back to back");

    AST_READ_LATENCY: assert property ( // [RULE11]
        rd_i && (addr_i == OFS_START_TASK || addr_i == OFS_STOP_TASK) |=> rdata_o == RESET_WORD)
        else $error("task register read not zero");

    COV_FIRST_BYTE: cover property ((state_reg == ST_RUN) && value_load && !evt_reg);
    COV_CORR_BYTE: cover property (corr_on && value_load);
    COV_BUF_STALL: cover property (byte_full_reg && !push_ready);
    COV_SHORT: cover property (short_stop);
endmodule

//--- src/trng_pkg.sv
// Constants, register map and state type for the random byte generator
//
// Behaviour
// RULE1 - A start task from a register write or subscribed channel begins generation.
// RULE2 - A stop task ends generation.
// RULE3 - While running, bytes are produced continuously and loaded into the value register.
// RULE4 - Exactly one value-ready event accompanies each new value register load.
// RULE5 - Each value is overwritten by the next; software reads it between events.
// RULE6 - With correction on, noise bits are debiased before byte assembly.
// RULE7 - Serial bits shift into a byte register, read out in parallel.
// RULE8 - A configuration bit switches bias correction; slower but uniform output.
// RULE9 - Byte time varies; consumers rely on the ready event, not cycle counts.
// RULE10 - Generation uses only the noise input, no software seed.
// RULE11 - Start and stop tasks are write-only at 0x000 and 0x004, triggered by 1.
// RULE12 - Subscribe registers at 0x080/0x084 hold channel index and enable bit.
// RULE13 - Publish register at 0x180 broadcasts value-ready onto a chosen channel.
// RULE14 - Shortcut register at 0x200 lets value-ready trigger stop in hardware.
// RULE15 - First byte starts after a one-time 128 us delay following start.
// RULE16 - Uncorrected bytes take typically 32 us each.
// RULE17 - Corrected bytes are specified up to 122 us, duration not guaranteed.
// RULE18 - Interrupt is high while the event flag and its enable are both set.
// RULE19 - Event flag stays set until software writes zero to the event register.
package trng_pkg;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_START_TASK = 12'h000;
    localparam logic [11:0] OFS_STOP_TASK = 12'h004;
    localparam logic [11:0] OFS_START_SUB = 12'h080;
    localparam logic [11:0] OFS_STOP_SUB = 12'h084;
    localparam logic [11:0] OFS_EVENT = 12'h100;
    localparam logic [11:0] OFS_PUBLISH = 12'h180;
    localparam logic [11:0] OFS_EVENT_TASK_SHORTCUTS = 12'h200;
    localparam logic [11:0] OFS_INTEN_SET = 12'h304;
    localparam logic [11:0] OFS_INTEN_CLR = 12'h308;
    localparam logic [11:0] OFS_CONFIG = 12'h504;
    localparam logic [11:0] OFS_VALUE = 12'h508;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Field layout
    localparam int TASK_TRIG_BIT = 0;
    localparam int CHAN_IDX_W = 8;
    localparam int NUM_CHANNELS = 256;
    localparam int CHAN_EN_BIT = 31;
    localparam logic [31:0] CHAN_MASK = 32'h800000FF;
    localparam int EVT_BIT = 0;
    localparam int SHORT_STOP_BIT = 0;
    localparam logic [31:0] EVENT_TASK_SHORTCUTS_MASK = 32'h00000001;
    localparam int INT_READY_BIT = 0;
    localparam int CFG_CORR_BIT = 0;
    localparam logic [31:0] CFG_MASK = 32'h00000001;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam int BYTE_W = 8;
    // Timing and buffer depth
    localparam int CLK_PERIOD_NS = 5;
    localparam int START_DELAY_US = 128;
    localparam int BYTE_TIME_US = 32;
    localparam int CORR_BYTE_MAX_US = 122;
    localparam int START_DELAY_CYC = (START_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int BIT_CYC = (BYTE_TIME_US * 1000) / (CLK_PERIOD_NS * BYTE_W);
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WARMUP = 2'h1,
        ST_RUN = 2'h2
    } trng_state_t;
endpackage

//--- src/trng_byte_buf.sv
// Small valid/ready buffer between the byte assembler and the value register
module trng_byte_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock, reset and flush
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[rptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else if (flush_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + AW'(1);
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + AW'(1);
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - (AW+1)'(1);
            end
        end
    end

    AST_BUF_BOUND: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE7]
        cnt_reg <= (AW+1)'(DEPTH))
        else $error("buffer count exceeds depth");
endmodule

//--- testbench/tb_trng_top.sv
// Self-checking testbench for the random byte generator
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("Error at %0t: got %h exp %h", $time, a, b); end end
module tb_trng_top
    import trng_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SDC = 20;
    localparam int BC = 4;
    localparam logic [11:0] OFS_UNMAPPED = 12'h0FC;
    logic clk_i, arst_n_i, noise_bit_i, wr_i, rd_i, irq_o, noise_tog;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o, rv;
    logic [NUM_CHANNELS-1:0] ev_chan_i, pub_chan_o;
    logic [1:0] tcnt;
    int fails, check_count, cycles, pub_cnt, n, base;

    trng_top #(.START_DELAY_CYCLES(SDC), .BIT_CYCLES(BC), .BUFFER_DEPTH(2)) i_trng_top (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .noise_bit_i(noise_bit_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ev_chan_i(ev_chan_i), .pub_chan_o(pub_chan_o),
        .irq_o(irq_o));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Published value-ready pulses on channel 5, and a cycle ceiling against hangs
    always @(posedge clk_i) begin
        if (pub_chan_o[5] === 1'b1) pub_cnt++;
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    // Optional slow square wave on the noise input, 4 cycles high, 4 low
    always @(posedge clk_i) begin
        if (noise_tog) begin
            tcnt <= tcnt + 2'h1;
            if (tcnt == 2'h3) noise_bit_i <= ~noise_bit_i;
        end
    end

    task automatic stop_test();
        $display("check_count=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask

    // Waits for the next published pulse and returns the cycles spent
    task automatic wait_pub(output int c);
        int s;
        s = pub_cnt;
        c = 0;
        while (pub_cnt == s && c < 400) begin
            @(posedge clk_i);
            #1 c++;
        end
    endtask

    task automatic pulse_chan(input int ch);
        @(posedge clk_i);
        ev_chan_i <= 256'h1 << ch;
        @(posedge clk_i);
        ev_chan_i <= '0;
    endtask

    task automatic t_reset();
        logic [11:0] al[12] = '{OFS_START_TASK, OFS_STOP_TASK, OFS_START_SUB, OFS_STOP_SUB, OFS_EVENT, OFS_PUBLISH,
            OFS_EVENT_TASK_SHORTCUTS, OFS_INTEN_SET, OFS_INTEN_CLR, OFS_CONFIG, OFS_VALUE, OFS_UNMAPPED};
        foreach (al[i]) begin
            rd(al[i], rv);
            `CHK(rv, RESET_WORD)
        end
        `CHK(irq_o, 1'b0)
    endtask

    task automatic t_regs();
        wr(OFS_START_SUB, 32'hFFFFFFFF); rd(OFS_START_SUB, rv); `CHK(rv, 32'h800000FF)
        wr(OFS_STOP_SUB, 32'h7FFFFF3C); rd(OFS_STOP_SUB, rv); `CHK(rv, 32'h0000003C)
        wr(OFS_PUBLISH, 32'hFFFFFFFF); rd(OFS_PUBLISH, rv); `CHK(rv, 32'h800000FF)
        wr(OFS_EVENT_TASK_SHORTCUTS, 32'hFFFFFFFF); rd(OFS_EVENT_TASK_SHORTCUTS, rv); `CHK(rv, 32'h00000001)
        wr(OFS_CONFIG, 32'hFFFFFFFF); rd(OFS_CONFIG, rv); `CHK(rv, 32'h00000001)
        wr(OFS_INTEN_SET, 32'h1); rd(OFS_INTEN_CLR, rv); `CHK(rv, 32'h00000001)
        wr(OFS_INTEN_CLR, 32'h1); rd(OFS_INTEN_SET, rv); `CHK(rv, 32'h00000000)
        wr(OFS_UNMAPPED, 32'hFFFFFFFF); rd(OFS_UNMAPPED, rv); `CHK(rv, 32'h00000000)
        wr(OFS_VALUE, 32'h000000A5); rd(OFS_VALUE, rv); `CHK(rv, 32'h00000000)
        wr(OFS_START_SUB, 32'h0); wr(OFS_STOP_SUB, 32'h0); wr(OFS_EVENT_TASK_SHORTCUTS, 32'h0); wr(OFS_CONFIG, 32'h0);
        wr(OFS_PUBLISH, 32'h80000005); rd(OFS_START_TASK, rv); `CHK(rv, 32'h00000000)
    endtask

    task automatic t_start();
        noise_bit_i <= 1'b1;
        wr(OFS_INTEN_SET, 32'h1);
        wr(OFS_START_TASK, 32'h1);
        wait_pub(n);
        `CHK(n >= SDC && n <= SDC + 8 * BC + 20, 1'b1)
        rd(OFS_VALUE, rv); `CHK(rv, 32'h000000FF)
        rd(OFS_EVENT, rv); `CHK(rv, 32'h00000001)
        `CHK(irq_o, 1'b1)
        wr(OFS_EVENT, 32'h1); rd(OFS_EVENT, rv); `CHK(rv, 32'h00000001)
        wr(OFS_EVENT, 32'h0); rd(OFS_EVENT, rv); `CHK(rv, 32'h00000000)
        `CHK(irq_o, 1'b0)
        wait_pub(n);
        wait_pub(n);
        `CHK(n >= 8 * BC - 4 && n <= 8 * BC + 8, 1'b1)
        noise_bit_i <= 1'b0;
        wait_pub(n); wait_pub(n);
        rd(OFS_VALUE, rv); `CHK(rv, 32'h00000000)
        wr(OFS_STOP_TASK, 32'h1);
        idle(3);
        base = pub_cnt;
        idle(120);
        `CHK(pub_cnt, base)
        wr(OFS_INTEN_CLR, 32'h1); wr(OFS_EVENT, 32'h0);
    endtask

    task automatic t_chan();
        noise_bit_i <= 1'b1;
        wr(OFS_START_SUB, 32'h80000007); wr(OFS_STOP_SUB, 32'h80000009);
        base = pub_cnt;
        pulse_chan(3);
        idle(120);
        `CHK(pub_cnt, base)
        pulse_chan(7);
        wait_pub(n); `CHK(n < 400, 1'b1)
        wr(OFS_START_TASK, 32'h1);
        wait_pub(n); `CHK(n <= 8 * BC + 8, 1'b1)
        pulse_chan(9);
        idle(3);
        base = pub_cnt;
        idle(120);
        `CHK(pub_cnt, base)
        @(posedge clk_i);
        ev_chan_i <= (256'h1 << 7) | (256'h1 << 9);
        @(posedge clk_i);
        ev_chan_i <= '0;
        idle(120);
        `CHK(pub_cnt, base)
        wr(OFS_EVENT_TASK_SHORTCUTS, 32'h1);
        pulse_chan(7);
        wait_pub(n); `CHK(n < 400, 1'b1)
        base = pub_cnt;
        idle(120);
        `CHK(pub_cnt, base)
        wr(OFS_EVENT_TASK_SHORTCUTS, 32'h0); wr(OFS_START_SUB, 32'h0); wr(OFS_STOP_SUB, 32'h0); wr(OFS_EVENT, 32'h0);
    endtask

    task automatic t_corr();
        noise_bit_i <= 1'b1;
        wr(OFS_CONFIG, 32'h1);
        wr(OFS_START_TASK, 32'h1);
        base = pub_cnt;
        idle(SDC + 160);
        `CHK(pub_cnt, base)
        noise_tog <= 1'b1;
        wait_pub(n); `CHK(n < 400, 1'b1)
        wr(OFS_STOP_TASK, 32'h1);
        noise_tog <= 1'b0;
        wr(OFS_CONFIG, 32'h0);
    endtask

    initial begin
        arst_n_i = 1'b0; noise_bit_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = '0; wdata_i = '0;
        ev_chan_i = '0; noise_tog = 1'b0; tcnt = 2'h0;
        fails = 0; check_count = 0; cycles = 0; pub_cnt = 0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_regs();
        t_start();
        t_chan();
        t_corr();
        stop_test();
    end
endmodule
